//--- core/csf_defines.svh
// Offsets, field positions, reset values and counts for the call stack and fetch block
`ifndef CSF_DEFINES_SVH
`define CSF_DEFINES_SVH
`define CSF_OFF_STACK_PTR 8'h00
`define CSF_OFF_CONTROL 8'h04
`define CSF_OFF_PROGRAM_COUNTER 8'h08
`define CSF_OFF_TABLE 8'h0C
`define CSF_OFF_CONTEXT 8'h10
`define CSF_OFF_EVENT 8'h14
`define CSF_BIT_FULL 7
`define CSF_BIT_UNDERFLOW 6
`define CSF_BIT_UNIMPL 5
`define CSF_STACK_PTR_RESET 8'h00
`define CSF_STACK_DEPTH 31
`define CSF_PC_WIDTH 21
`define CSF_PHASE_COUNT 4
`define CSF_PC_STEP 21'h000002
`endif

//--- core/csf_pkg.sv
// Types shared by the call stack and fetch block
package csf_pkg;
  typedef enum logic [1:0] {
    CSF_PHASE_ONE,
    CSF_PHASE_TWO,
    CSF_PHASE_THREE,
    CSF_PHASE_FOUR
  } csf_phase_type;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] working;
    logic [7:0] bank;
  } csf_context_type;

  typedef struct packed {
    logic push;
    logic pop;
    logic fast_save;
    logic fast_restore;
    logic branch;
    logic [20:0] target;
    logic pcl_add;
    logic [7:0] pcl_offset;
  } csf_flow_type;
endpackage : csf_pkg

//--- core/csf_phase_gen.sv
// Divide-by-four phase generator for the instruction cycle
`timescale 1ns/100ps
module csf_phase_gen
  import csf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  output csf_phase_type phase
);
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      phase <= CSF_PHASE_ONE;
    end else begin
      unique case (phase)
        CSF_PHASE_ONE: phase <= CSF_PHASE_TWO;
        CSF_PHASE_TWO: phase <= CSF_PHASE_THREE;
        CSF_PHASE_THREE: phase <= CSF_PHASE_FOUR;
        CSF_PHASE_FOUR: phase <= CSF_PHASE_ONE;
      endcase
    end
  end

  a_phase_order: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE15
    phase == CSF_PHASE_FOUR |=> phase == CSF_PHASE_ONE)
    else $error("phase four not followed by phase one");
endmodule : csf_phase_gen

//--- core/csf_return_stack.sv
// Return address stack memory with pointer and fault flags
`timescale 1ns/100ps
`include "csf_defines.svh"
module csf_return_stack
  import csf_pkg::*;
#(
  parameter int DEPTH = `CSF_STACK_DEPTH,
  parameter int AW = 21
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic push,
  input wire logic pop,
  input wire logic [AW-1:0] push_data,
  input wire logic fault_reset_enable,
  input wire logic sw_write,
  input wire logic [7:0] sw_data,
  output logic [AW-1:0] top_data,
  output logic [4:0] level,
  output logic full_flag,
  output logic underflow_flag,
  output logic full_event,
  output logic underflow_event
);
  logic [AW-1:0] mem [1:DEPTH];
  logic at_top;
  logic at_bottom;
  assign at_top = (level == 5'(DEPTH));
  assign at_bottom = (level == 5'h00);
  assign top_data = at_bottom ? '0 : mem[level]; // RULE23
  assign full_event = push && (at_top || level == 5'(DEPTH - 1));
  assign underflow_event = pop && at_bottom;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      level <= 5'h00;
    end else if (sw_write) begin
      level <= sw_data[4:0]; // RULE4
    end else if (push && !at_top) begin
      level <= level + 5'h01; // RULE21
    end else if (pop && !at_bottom) begin
      level <= level - 5'h01; // RULE21
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push && !at_top && !sw_write) begin
      mem[level + 5'h01] <= push_data; // RULE21 RULE22
    end
  end

  // Flags survive a stack fault reset; only software or power-on clears them
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      full_flag <= 1'b0;
      underflow_flag <= 1'b0;
    end else begin
      if (full_event) begin
        full_flag <= 1'b1; // RULE1
      end else if (sw_write && !sw_data[`CSF_BIT_FULL]) begin
        full_flag <= 1'b0; // RULE5
      end
      if (underflow_event) begin
        underflow_flag <= 1'b1; // RULE2
      end else if (sw_write && !sw_data[`CSF_BIT_UNDERFLOW]) begin
        underflow_flag <= 1'b0; // RULE5
      end
    end
  end

  a_full_stays_top: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE22
    push && at_top && !sw_write && !fault_reset_enable |=> at_top)
    else $error("pointer left level 31 on overflow push");
  a_flag_set_push: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE1
    full_event |=> full_flag)
    else $error("full flag not set");
  a_under_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE5
    underflow_flag && !sw_write |=> underflow_flag)
    else $error("underflow flag cleared without software");
  a_under_level: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE2 RULE23
    pop && at_bottom && !sw_write |=> at_bottom && underflow_flag)
    else $error("underflow pop moved pointer");
endmodule : csf_return_stack

//--- core/csf_core_flow.sv
// Program flow core: call stack, shadow context, phases, fetch pipeline, AXI4-Lite slave
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "csf_defines.svh"
// Operation
// [RULE1] Full flag bit 7 on full or overflow
// [RULE2] Underflow flag bit 6 on empty pop
// [RULE3] Bit 5 ignores writes, reads zero
// [RULE4] Low five bits are level, read/write, reset zero
// [RULE5] Flags sticky until software or power-on clear
// [RULE6] Fault reset enabled: set flag, then reset
// [RULE7] Fault reset disabled: set flag only
// [RULE8] Single hidden shadow of status, working, bank
// [RULE9] Any interrupt vector captures shadow context
// [RULE10] Fast interrupt return restores shadow context
// [RULE11] High priority nested interrupt overwrites shadow
// [RULE12] Fast call saves, fast return restores
// [RULE13] Adding to low PC byte jumps bytes
// [RULE14] Table pointer byte read into table latch
// [RULE15] Clock divided into four phases
// [RULE16] PC increments in phase one
// [RULE17] Instruction latched in phase four, executed next
// [RULE18] Operand read phase two, write phase four
// [RULE19] Fetch overlaps execute, one cycle throughput
// [RULE20] PC change flushes fetched word, two cycles
// [RULE21] 31 by 21 stack, pre-increment, post-decrement
// [RULE22] Disabled fault reset: overflow keeps pointer 31
// [RULE23] Empty pop returns zero, pointer stays zero
// [RULE24] Reset restarts phase one, flushes pipeline
module csf_core_flow
  import csf_pkg::*;
#(
  parameter int PCW = `CSF_PC_WIDTH
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Program memory
  output logic [PCW-1:0] prog_addr,
  input wire logic [15:0] prog_word,
  output logic [PCW-1:0] table_addr,
  input wire logic [7:0] table_byte,
  // Execute side requests, sampled in phase four
  input wire csf_flow_type flow_req,
  input wire logic table_read_req,
  input wire logic interrupt_vector,
  input wire logic [PCW-1:0] vector_addr,
  input wire csf_context_type live_context,
  // Pipeline status and strobes
  output logic [15:0] instruction_latch,
  output logic exec_valid,
  output logic phase_one,
  output logic phase_two,
  output logic phase_three,
  output logic phase_four,
  output logic operand_read,
  output logic dest_write,
  output csf_context_type restore_context,
  output logic restore_strobe,
  output logic [7:0] table_latch,
  output logic device_reset
);
  // ------------------------------------------------------------
  // Phase generator and internal reset
  // ------------------------------------------------------------
  csf_phase_type phase;
  logic core_rst_n;
  logic fault_reset_enable;
  logic fault_pending;
  logic [7:0] sw_ptr_data;
  logic sw_ptr_write;
  logic full_event;
  logic underflow_event;

  // Stack fault reset leaves flags intact; it restarts the pipeline and clears the stack pointer level
  assign core_rst_n = rst_n && !device_reset; // RULE24

  csf_phase_gen u_phase (
    .sys_clk(sys_clk),
    .rst_n(core_rst_n),
    .phase(phase)
  ); // RULE15

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      phase_one <= 1'b1;
      phase_two <= 1'b0;
      phase_three <= 1'b0;
      phase_four <= 1'b0;
    end else begin
      phase_one <= (phase == CSF_PHASE_FOUR) || device_reset; // RULE15
      phase_two <= (phase == CSF_PHASE_ONE) && !device_reset;
      phase_three <= (phase == CSF_PHASE_TWO) && !device_reset;
      phase_four <= (phase == CSF_PHASE_THREE) && !device_reset;
    end
  end

  // Flag set comes first, reset follows one cycle later
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fault_pending <= 1'b0;
      device_reset <= 1'b0;
    end else begin
      fault_pending <= fault_reset_enable && (full_event || underflow_event); // RULE6 RULE7
      device_reset <= fault_pending; // RULE6
    end
  end

  // ------------------------------------------------------------
  // Return stack
  // ------------------------------------------------------------
  logic [PCW-1:0] pc;
  logic [PCW-1:0] top_data;
  logic [4:0] level;
  logic full_flag;
  logic underflow_flag;
  logic do_exec;
  logic stack_push;
  logic stack_pop;

  assign do_exec = (phase == CSF_PHASE_FOUR) && exec_valid;
  assign stack_push = do_exec && (flow_req.push || interrupt_vector);
  assign stack_pop = do_exec && flow_req.pop && !interrupt_vector;

  csf_return_stack #(
    .DEPTH(`CSF_STACK_DEPTH),
    .AW(PCW)
  ) u_stack (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .push(stack_push),
    .pop(stack_pop),
    .push_data(pc),
    .fault_reset_enable(fault_reset_enable),
    .sw_write(sw_ptr_write || device_reset),
    .sw_data(device_reset ? {full_flag, underflow_flag, 6'h00} : sw_ptr_data),
    .top_data(top_data),
    .level(level),
    .full_flag(full_flag),
    .underflow_flag(underflow_flag),
    .full_event(full_event),
    .underflow_event(underflow_event)
  );

  // ------------------------------------------------------------
  // Shadow context, hidden from software
  // ------------------------------------------------------------
  csf_context_type shadow_context; // RULE8

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      shadow_context <= '0;
    end else if (do_exec && (interrupt_vector || flow_req.fast_save)) begin
      shadow_context <= live_context; // RULE9 RULE11 RULE12
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!core_rst_n) begin
      restore_context <= '0;
      restore_strobe <= 1'b0;
    end else begin
      restore_strobe <= do_exec && flow_req.fast_restore && !interrupt_vector; // RULE10 RULE12
      restore_context <= shadow_context;
    end
  end

  // ------------------------------------------------------------
  // Program counter and fetch/execute pipeline
  // ------------------------------------------------------------
  logic [PCW-1:0] next_pc;
  logic redirect;

  assign redirect = do_exec && (interrupt_vector || flow_req.branch || flow_req.pop
    || flow_req.pcl_add);

  always_comb begin
    next_pc = pc;
    if (interrupt_vector) begin
      next_pc = vector_addr;
    end else if (flow_req.pop) begin
      next_pc = top_data; // RULE23
    end else if (flow_req.branch) begin
      next_pc = flow_req.target;
    end else if (flow_req.pcl_add) begin
      next_pc = {pc[PCW-1:8], pc[7:0] + flow_req.pcl_offset}; // RULE13
    end
    next_pc[0] = 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (!core_rst_n) begin
      pc <= '0;
    end else if (redirect) begin
      pc <= next_pc; // RULE20
    end else if (phase == CSF_PHASE_ONE) begin
      pc <= pc + `CSF_PC_STEP; // RULE16
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!core_rst_n) begin
      prog_addr <= '0;
    end else begin
      prog_addr <= pc;
    end
  end

  // A redirect discards the word already fetched, costing one extra cycle
  always_ff @(posedge sys_clk) begin
    if (!core_rst_n) begin
      instruction_latch <= 16'h0000;
      exec_valid <= 1'b0; // RULE24
    end else if (phase == CSF_PHASE_FOUR) begin
      instruction_latch <= prog_word; // RULE17 RULE19
      exec_valid <= !redirect; // RULE20
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!core_rst_n) begin
      operand_read <= 1'b0;
      dest_write <= 1'b0;
    end else begin
      operand_read <= exec_valid && (phase == CSF_PHASE_ONE); // RULE18
      dest_write <= exec_valid && (phase == CSF_PHASE_THREE); // RULE18
    end
  end

  // ------------------------------------------------------------
  // Table read
  // ------------------------------------------------------------
  logic [PCW-1:0] table_pointer;
  logic tbl_ptr_write;
  logic [31:0] tbl_ptr_data;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      table_pointer <= '0;
    end else if (tbl_ptr_write) begin
      table_pointer <= tbl_ptr_data[PCW-1:0];
    end
  end

  assign table_addr = table_pointer; // RULE14

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      table_latch <= 8'h00;
    end else if (do_exec && table_read_req) begin
      table_latch <= table_byte; // RULE14
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite slave
  // ------------------------------------------------------------
  logic [7:0] wr_addr;
  logic aw_held;
  logic w_held;
  logic [31:0] wr_data;
  logic wr_go;
  logic wr_ok;

  assign wr_go = aw_held && w_held && !s_axi_bvalid;
  assign wr_ok = (wr_addr == `CSF_OFF_STACK_PTR) || (wr_addr == `CSF_OFF_CONTROL)
    || (wr_addr == `CSF_OFF_TABLE);
  assign sw_ptr_write = wr_go && (wr_addr == `CSF_OFF_STACK_PTR);
  assign sw_ptr_data = {wr_data[7:6], 1'b0, wr_data[4:0]}; // RULE3
  assign tbl_ptr_write = wr_go && (wr_addr == `CSF_OFF_TABLE);
  assign tbl_ptr_data = wr_data;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 32'h0000_0000;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        wr_addr <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        wr_data <= s_axi_wstrb[0] ? s_axi_wdata : {24'h000000, {full_flag, underflow_flag,
          1'b0, level}};
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fault_reset_enable <= 1'b1;
    end else if (wr_go && wr_addr == `CSF_OFF_CONTROL && s_axi_wstrb != 4'h0) begin
      fault_reset_enable <= wr_data[0]; // RULE6 RULE7
    end
  end

  // Remembers that the pending read answer belongs to the pointer register
  logic rd_ptr_sel;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_ptr_sel <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rd_ptr_sel <= ({s_axi_araddr[7:2], 2'h0} == `CSF_OFF_STACK_PTR);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        unique case ({s_axi_araddr[7:2], 2'h0})
          `CSF_OFF_STACK_PTR: s_axi_rdata <= {24'h000000, full_flag, underflow_flag, 1'b0,
            level}; // RULE3 RULE4
          `CSF_OFF_CONTROL: s_axi_rdata <= {31'h0, fault_reset_enable};
          `CSF_OFF_PROGRAM_COUNTER: s_axi_rdata <= {11'h000, pc};
          `CSF_OFF_TABLE: s_axi_rdata <= {3'h0, table_latch, table_pointer};
          `CSF_OFF_EVENT: s_axi_rdata <= {16'h0000, instruction_latch};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_fault_seen;
    fault_reset_enable && (full_event || underflow_event);
  endsequence

  sequence s_reset_pulse;
    !device_reset ##1 device_reset;
  endsequence

  a_fault_then_reset: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE6
    s_fault_seen |=> s_reset_pulse)
    else $error("stack fault did not reset after flag");
  a_no_fault_reset: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE7
    !fault_reset_enable && !fault_pending |=> !device_reset)
    else $error("reset without enable");
  a_pc_step_one: assert property (@(posedge sys_clk) disable iff (!core_rst_n) // RULE16
    phase == CSF_PHASE_ONE && !redirect |=> pc == $past(pc) + `CSF_PC_STEP)
    else $error("pc did not step in phase one");
  a_flush_branch: assert property (@(posedge sys_clk) disable iff (!core_rst_n) // RULE20
    redirect |=> !exec_valid ##1 pc == $past(next_pc, 2) + `CSF_PC_STEP)
    else $error("redirect did not flush");
  a_shadow_capture: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE9 RULE11
    do_exec && interrupt_vector |=> shadow_context == $past(live_context))
    else $error("shadow not captured on interrupt");
  a_reg_read_zero: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE3
    s_axi_rvalid && rd_ptr_sel |-> !s_axi_rdata[`CSF_BIT_UNIMPL])
    else $error("bit 5 of pointer read as one");
  a_latch_phase_four: assert property (@(posedge sys_clk) disable iff (!core_rst_n) // RULE17
    phase != CSF_PHASE_FOUR |=> $stable(instruction_latch))
    else $error("instruction latch moved outside phase four");
  a_strobe_phases: assert property (@(posedge sys_clk) disable iff (!core_rst_n) // RULE18
    operand_read |-> phase == CSF_PHASE_TWO ##2 dest_write == exec_valid)
    else $error("operand strobes out of phase");
endmodule : csf_core_flow

//--- dv/csf_prog_model.sv
// Program memory model facing the fetch and table ports
`timescale 1ns/100ps
module csf_prog_model
  import csf_pkg::*;
(
  input wire logic [20:0] prog_addr,
  input wire logic [20:0] table_addr,
  output logic [15:0] prog_word,
  output logic [7:0] table_byte
);
  // --------------------------------------------------
  // Read-only contents derived from the address
  // --------------------------------------------------
  // Word depends on address so a stale fetch shows up as a wrong word
  assign prog_word = prog_addr[15:0] ^ 16'hA5C3;
  // One byte per table access, picked by the byte address
  assign table_byte = table_addr[7:0] ^ 8'h5A;
endmodule : csf_prog_model

//--- dv/call_stack_and_fetch_pipeline_tb_top.sv
// Self-checking bench for the call stack and fetch block
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module call_stack_and_fetch_pipeline_tb_top
  import csf_pkg::*;
;
  logic sys_clk, rst_n;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [20:0] prog_addr, table_addr, vector_addr;
  logic [15:0] prog_word, instruction_latch;
  logic [7:0] table_byte, table_latch;
  csf_flow_type flow_req;
  csf_context_type live_context, restore_context, got_ctx;
  logic table_read_req, interrupt_vector, exec_valid, restore_strobe, device_reset;
  logic phase_one, phase_two, phase_three, phase_four, operand_read, dest_write;
  int n_errors, num_checks, n_dres, n_strobe, cyc, gap;
  logic p1_prev, gap_ok;

  csf_core_flow u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .prog_addr(prog_addr), .prog_word(prog_word),
    .table_addr(table_addr), .table_byte(table_byte), .flow_req(flow_req),
    .table_read_req(table_read_req), .interrupt_vector(interrupt_vector),
    .vector_addr(vector_addr), .live_context(live_context),
    .instruction_latch(instruction_latch), .exec_valid(exec_valid),
    .phase_one(phase_one), .phase_two(phase_two), .phase_three(phase_three),
    .phase_four(phase_four), .operand_read(operand_read), .dest_write(dest_write),
    .restore_context(restore_context), .restore_strobe(restore_strobe),
    .table_latch(table_latch), .device_reset(device_reset));

  csf_prog_model u_prog (.prog_addr(prog_addr), .table_addr(table_addr),
    .prog_word(prog_word), .table_byte(table_byte));

  always #5 sys_clk = ~sys_clk;

  // --------------------------------------------------
  // Monitors
  // --------------------------------------------------
  always @(posedge sys_clk) begin
    cyc++;
    if (restore_strobe === 1'b1) begin
      got_ctx <= restore_context;
      n_strobe++;
    end
    if (device_reset === 1'b1) begin
      n_dres++;
      gap_ok = 1'b0;
    end
    if (rst_n === 1'b1 && cyc > 12) begin
      `CHK($onehot({phase_one, phase_two, phase_three, phase_four}), 1'b1)
      `CHK(prog_addr[0], 1'b0)
      if (operand_read === 1'b1) `CHK(phase_two, 1'b1)
      if (dest_write === 1'b1) `CHK(phase_four, 1'b1)
      if (phase_one === 1'b1 && p1_prev === 1'b0) begin
        if (gap_ok) `CHK(gap, 4)
        gap_ok = 1'b1;
        gap = 0;
      end
    end
    gap++;
    p1_prev = phase_one;
    if (cyc == 20000) begin
      n_errors++;
      summarize();
    end
  end

  // --------------------------------------------------
  // Register bus and execute-side tasks
  // --------------------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(posedge sys_clk);
      if (aw && s_axi_awready === 1'b1) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge sys_clk);
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, 2'h0)
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge sys_clk);
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rresp, r)
    if (r == 2'h0) `CHK(s_axi_rdata, e)
  endtask : axi_rd

  // Bits: push, pop, save, restore, interrupt, table read
  task automatic op(input logic [5:0] k);
    @(posedge sys_clk);
    flow_req <= '{push: k[5], pop: k[4], fast_save: k[3], fast_restore: k[2], default: '0};
    interrupt_vector <= k[1];
    table_read_req <= k[0];
    // Four edges hold the request across exactly one phase-four sample
    repeat (4) @(posedge sys_clk);
    flow_req <= '0;
    interrupt_vector <= 1'b0;
    table_read_req <= 1'b0;
    // Room for a flush and refill after any flow change
    repeat (12) @(posedge sys_clk);
  endtask : op

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  // --------------------------------------------------
  // Main sequence
  // --------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    flow_req = '0;
    {table_read_req, interrupt_vector} = '0;
    vector_addr = 21'h000100;
    live_context = '0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    axi_rd(8'h00, 32'h00000000, 2'h0);
    axi_rd(8'h04, 32'h00000001, 2'h0);
    axi_wr(8'h00, 32'h000000FF);
    axi_rd(8'h00, 32'h0000001F, 2'h0);
    axi_rd(8'h10, 32'h00000000, 2'h2);
    axi_wr(8'h04, 32'h00000000);
    axi_wr(8'h00, 32'h0000001E);
    op(6'h20);
    axi_rd(8'h00, 32'h0000009F, 2'h0);
    op(6'h20);
    axi_rd(8'h00, 32'h0000009F, 2'h0);
    `CHK(n_dres, 0)
    axi_wr(8'h00, 32'h0000001F);
    axi_rd(8'h00, 32'h0000001F, 2'h0);
    axi_wr(8'h00, 32'h00000000);
    op(6'h10);
    axi_rd(8'h00, 32'h00000040, 2'h0);
    op(6'h20);
    axi_rd(8'h00, 32'h00000041, 2'h0);
    axi_wr(8'h00, 32'h00000000);
    axi_wr(8'h04, 32'h00000001);
    op(6'h10);
    `CHK(n_dres, 1)
    axi_rd(8'h00, 32'h00000040, 2'h0);
    live_context <= 24'h112233;
    op(6'h08);
    live_context <= 24'h445566;
    op(6'h04);
    `CHK(got_ctx, 24'h112233)
    live_context <= 24'h778899;
    op(6'h02);
    live_context <= 24'hAABBCC;
    op(6'h04);
    `CHK(got_ctx, 24'h778899)
    live_context <= 24'h010203;
    op(6'h02);
    live_context <= 24'h040506;
    op(6'h02);
    live_context <= 24'h000000;
    op(6'h04);
    `CHK(got_ctx, 24'h040506)
    `CHK(n_strobe, 3)
    axi_wr(8'h0C, 32'h00000123);
    op(6'h01);
    axi_rd(8'h0C, 32'h0F200123, 2'h0);
    `CHK(table_latch, 8'h79)
    summarize();
  end
endmodule : call_stack_and_fetch_pipeline_tb_top
